/* rtl/dtm_core.sv */
`timescale 1ns/10ps
module dtm_core #(
  parameter int RATE_UNIT_CYCLES = dtm_pkg::RATE_UNIT_CYCLES
) (
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // serial bus sampling clock and pins
  input wire logic LINK_CLK,
  input wire logic SCLK,
  input wire logic SDATA_IN,
  output logic SDATA_OUT,
  output logic SDATA_OE,
  // mode pin and alert
  input wire logic STANDBY_SELECT_PIN,
  output logic ALERT_B,
  // converter front end
  output logic ADC_CHANNEL,
  output logic ADC_BIAS_HIGH,
  output logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [10:0] ADC_DATA
);
  // ==========================================
  // helpers
  function automatic dtm_pkg::dtm_temp_t widen(input logic [7:0] b);
    return dtm_pkg::dtm_temp_t'({b, 3'h0});
  endfunction

  function automatic logic [1:0] out_of_range(input dtm_pkg::dtm_temp_t v, input dtm_pkg::dtm_temp_t hi,
                                              input dtm_pkg::dtm_temp_t lo);
    return {v > hi, v < lo};
  endfunction

  // clamps instead of wrapping past either end of the range
  function automatic dtm_pkg::dtm_temp_t sat_add(input dtm_pkg::dtm_temp_t a, input dtm_pkg::dtm_temp_t b);
    logic signed [11:0] s;
    s = {a[10], a} + {b[10], b};
    if (s[11] != s[10]) begin
      return s[11] ? dtm_pkg::dtm_temp_t'(12'h400) : dtm_pkg::dtm_temp_t'(12'h3ff);
    end
    return dtm_pkg::dtm_temp_t'(s[10:0]);
  endfunction

  typedef enum {S_INIT, S_IDLE, S_START_LO, S_WAIT_LO, S_START_HI, S_WAIT_HI, S_STORE, S_COMPARE,
                S_WAIT} dtm_conv_e;

  dtm_conv_e state_reg;
  logic standby_select_pin_pin_s, wr_tgl_link, rd_tgl_link, wr_tgl_s, rd_tgl_s, wr_tgl_d, rd_tgl_d;
  logic wr_evt, rd_evt, status_read, standby, busy, rd_ack_reg, channel_reg;
  dtm_pkg::dtm_wr_s wr_word_link;
  logic [7:0] pointer_reg, config_reg, rd_data_reg, rd_mux, local_value_reg, offset_high_reg, offset_low_reg;
  logic [7:0] local_hlim_reg, local_llim_reg;
  logic [2:0] rate_reg;
  logic [1:0] init_cnt_reg;
  logic [3:0] sample_cnt_reg;
  logic [14:0] acc_reg;
  logic [31:0] wait_cnt_reg;
  dtm_pkg::dtm_temp_t remote_value_reg, remote_hlim_reg, remote_llim_reg, avg, offset;
  dtm_pkg::dtm_flags_s flags_reg, flags_set;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // ==========================================
  // serial bus engine and crossings
  dtm_smbus_slave u_link (
    .link_clk(LINK_CLK),
    .rst_b(RST_B),
    .scl_in(SCLK),
    .sda_in(SDATA_IN),
    .sda_out(SDATA_OUT),
    .sda_oe(SDATA_OE),
    .wr_word(wr_word_link),
    .wr_toggle(wr_tgl_link),
    .rd_toggle(rd_tgl_link),
    .rd_ack_toggle(rd_ack_reg),
    .rd_data(rd_data_reg)
  );

  dtm_sync2 #(.RESET_VAL(1'b1)) u_standby_select_pin (.clk(CLOCK), .rst_b(RST_B), .d(STANDBY_SELECT_PIN), .q(standby_select_pin_pin_s));
  dtm_sync2 u_wr (.clk(CLOCK), .rst_b(RST_B), .d(wr_tgl_link), .q(wr_tgl_s));
  dtm_sync2 u_rd (.clk(CLOCK), .rst_b(RST_B), .d(rd_tgl_link), .q(rd_tgl_s));

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wr_tgl_d <= 1'b0;
      rd_tgl_d <= 1'b0;
    end else begin
      wr_tgl_d <= wr_tgl_s;
      rd_tgl_d <= rd_tgl_s;
    end
  end

  // the link holds its write word until the next toggle, so it is stable here
  assign wr_evt = wr_tgl_s ^ wr_tgl_d;
  assign rd_evt = rd_tgl_s ^ rd_tgl_d;
  assign status_read = rd_evt && (pointer_reg == dtm_pkg::REG_STATUS);
  assign standby = !standby_select_pin_pin_s || config_reg[dtm_pkg::CFG_STANDBY_BIT];
  assign offset = dtm_pkg::dtm_temp_t'({offset_high_reg, offset_low_reg[7:5]});
  assign busy = !(state_reg inside {S_INIT, S_IDLE, S_WAIT});

  // ==========================================
  // host writes
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pointer_reg <= 8'h00;
      config_reg <= dtm_pkg::CONFIG_RESET;
      rate_reg <= dtm_pkg::RATE_RESET;
      offset_high_reg <= dtm_pkg::OFFSET_RESET;
      offset_low_reg <= dtm_pkg::OFFSET_RESET;
      local_hlim_reg <= dtm_pkg::LOCAL_HLIM_RESET;
      local_llim_reg <= dtm_pkg::LOCAL_LLIM_RESET;
      remote_hlim_reg <= dtm_pkg::REMOTE_HLIM_RESET;
      remote_llim_reg <= dtm_pkg::REMOTE_LLIM_RESET;
    end else if (wr_evt) begin
      if (wr_word_link.first) begin
        pointer_reg <= wr_word_link.data;
      end else begin
        case (pointer_reg)
          dtm_pkg::REG_CONFIG: config_reg <= wr_word_link.data;
          dtm_pkg::REG_RATE: rate_reg <= wr_word_link.data[2:0];
          dtm_pkg::REG_OFFSET_HIGH: offset_high_reg <= wr_word_link.data;
          dtm_pkg::REG_OFFSET_LOW: offset_low_reg <= {wr_word_link.data[7:5], 5'h00};
          dtm_pkg::REG_LOCAL_HLIM: local_hlim_reg <= wr_word_link.data;
          dtm_pkg::REG_LOCAL_LLIM: local_llim_reg <= wr_word_link.data;
          dtm_pkg::REG_REMOTE_HLIM_HIGH: remote_hlim_reg[10:3] <= wr_word_link.data;
          dtm_pkg::REG_REMOTE_LLIM_HIGH: remote_llim_reg[10:3] <= wr_word_link.data;
          dtm_pkg::REG_REMOTE_HLIM_LOW: remote_hlim_reg[2:0] <= wr_word_link.data[7:5];
          dtm_pkg::REG_REMOTE_LLIM_LOW: remote_llim_reg[2:0] <= wr_word_link.data[7:5];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================
  // host reads
  always_comb begin
    case (pointer_reg)
      dtm_pkg::REG_LOCAL_VALUE: rd_mux = local_value_reg;
      dtm_pkg::REG_REMOTE_HIGH: rd_mux = remote_value_reg[10:3];
      dtm_pkg::REG_REMOTE_LOW: rd_mux = {remote_value_reg[2:0], 5'h00};
      dtm_pkg::REG_STATUS: rd_mux = {busy, flags_reg, 3'h0};
      dtm_pkg::REG_CONFIG: rd_mux = config_reg;
      dtm_pkg::REG_RATE: rd_mux = {5'h00, rate_reg};
      dtm_pkg::REG_OFFSET_HIGH: rd_mux = offset_high_reg;
      dtm_pkg::REG_OFFSET_LOW: rd_mux = offset_low_reg;
      dtm_pkg::REG_LOCAL_HLIM: rd_mux = local_hlim_reg;
      dtm_pkg::REG_LOCAL_LLIM: rd_mux = local_llim_reg;
      dtm_pkg::REG_REMOTE_HLIM_HIGH: rd_mux = remote_hlim_reg[10:3];
      dtm_pkg::REG_REMOTE_LLIM_HIGH: rd_mux = remote_llim_reg[10:3];
      dtm_pkg::REG_REMOTE_HLIM_LOW: rd_mux = {remote_hlim_reg[2:0], 5'h00};
      dtm_pkg::REG_REMOTE_LLIM_LOW: rd_mux = {remote_llim_reg[2:0], 5'h00};
      default: rd_mux = dtm_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rd_data_reg <= 8'h00;
      rd_ack_reg <= 1'b0;
    end else if (rd_evt) begin
      rd_data_reg <= rd_mux;
      rd_ack_reg <= rd_tgl_s;
    end
  end

  // ==========================================
  // conversion sequencer
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= S_INIT;
      init_cnt_reg <= 2'h0;
      channel_reg <= 1'b0;
      ADC_BIAS_HIGH <= 1'b0;
      ADC_START <= 1'b0;
      sample_cnt_reg <= 4'h0;
      acc_reg <= 15'h0000;
      wait_cnt_reg <= 32'h0000_0000;
    end else begin
      ADC_START <= 1'b0;
      case (state_reg)
        S_INIT: begin
          // lets the standby pin settle through its synchroniser
          init_cnt_reg <= init_cnt_reg + 2'h1;
          if (init_cnt_reg == dtm_pkg::INIT_LAST) begin
            state_reg <= standby ? S_IDLE : S_START_LO;
          end
        end
        S_IDLE: begin
          acc_reg <= 15'h0000;
          sample_cnt_reg <= 4'h0;
          if (!standby) begin
            state_reg <= S_START_LO;
          end
        end
        S_START_LO: begin
          if (standby) begin
            state_reg <= S_IDLE;
          end else begin
            ADC_BIAS_HIGH <= 1'b0;
            ADC_START <= 1'b1;
            state_reg <= S_WAIT_LO;
          end
        end
        S_WAIT_LO: begin
          if (ADC_DONE) begin
            state_reg <= S_START_HI;
          end
        end
        S_START_HI: begin
          ADC_BIAS_HIGH <= 1'b1;
          ADC_START <= 1'b1;
          state_reg <= S_WAIT_HI;
        end
        S_WAIT_HI: begin
          if (ADC_DONE) begin
            acc_reg <= acc_reg + {{4{ADC_DATA[10]}}, ADC_DATA};
            sample_cnt_reg <= sample_cnt_reg + 4'h1;
            state_reg <= (sample_cnt_reg == dtm_pkg::AVG_LAST) ? S_STORE : S_START_LO;
          end
        end
        S_STORE: state_reg <= S_COMPARE;
        S_COMPARE: begin
          acc_reg <= 15'h0000;
          channel_reg <= ~channel_reg;
          if (standby) begin
            state_reg <= S_IDLE;
          end else if (channel_reg) begin
            wait_cnt_reg <= 32'(RATE_UNIT_CYCLES) << (dtm_pkg::RATE_MAX - rate_reg);
            state_reg <= S_WAIT;
          end else begin
            state_reg <= S_START_LO;
          end
        end
        S_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg - 32'h1;
          if (standby) begin
            state_reg <= S_IDLE;
          end else if (wait_cnt_reg == 32'h0) begin
            state_reg <= S_START_LO;
          end
        end
        default: state_reg <= S_INIT;
      endcase
    end
  end

  assign ADC_CHANNEL = channel_reg;
  assign avg = dtm_pkg::dtm_temp_t'(acc_reg[14:dtm_pkg::AVG_SHIFT]);

  // ==========================================
  // result storage
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      local_value_reg <= dtm_pkg::VALUE_RESET;
      remote_value_reg <= dtm_pkg::dtm_temp_t'({dtm_pkg::VALUE_RESET, 3'h0});
    end else if (state_reg == S_STORE) begin
      if (!channel_reg) begin
        local_value_reg <= avg[10:dtm_pkg::FRAC_BITS];
      end else begin
        remote_value_reg <= sat_add(avg, offset);
      end
    end
  end

  // ==========================================
  // comparisons, flags and alert
  always_comb begin
    flags_set = '0;
    if ((state_reg == S_COMPARE && !channel_reg) ||
        (state_reg == S_INIT && init_cnt_reg == dtm_pkg::INIT_LAST && standby)) begin
      {flags_set.local_high, flags_set.local_under_limit_flag} =
        out_of_range(widen(local_value_reg), widen(local_hlim_reg), widen(local_llim_reg));
    end
    if ((state_reg == S_COMPARE && channel_reg) ||
        (state_reg == S_INIT && init_cnt_reg == dtm_pkg::INIT_LAST && standby)) begin
      {flags_set.remote_high, flags_set.remote_under_limit_flag} =
        out_of_range(remote_value_reg, remote_hlim_reg, remote_llim_reg);
    end
  end

  // a flag raised in the same cycle as the status read survives it
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (status_read ? dtm_pkg::dtm_flags_s'(4'h0) : flags_reg) | flags_set;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ALERT_B <= 1'b1;
    end else begin
      ALERT_B <= !((|flags_reg) && !config_reg[dtm_pkg::CFG_MASK_BIT]);
    end
  end

  // ==========================================
  // checks
  logic [4:0] hi_done_cnt;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      hi_done_cnt <= 5'h00;
    end else if (state_reg == S_COMPARE || state_reg == S_IDLE) begin
      hi_done_cnt <= 5'h00;
    end else if (state_reg == S_WAIT_HI && ADC_DONE) begin
      hi_done_cnt <= hi_done_cnt + 5'h01;
    end
  end

  sequence lo_done_s;
    state_reg == S_WAIT_LO && ADC_DONE;
  endsequence
  sequence hi_start_s;
    ADC_START && ADC_BIAS_HIGH;
  endsequence

  bias_order_a: assert property (lo_done_s |-> ##2 hi_start_s)
    else $error("high bias start did not follow low bias conversion");
  avg_sixteen_a: assert property (state_reg == S_STORE |-> hi_done_cnt == 5'h10)
    else $error("result stored without sixteen measurements");
  store_compare_a: assert property (state_reg == S_STORE |=> state_reg == S_COMPARE)
    else $error("stored result not compared next");
  local_store_a: assert property (state_reg == S_STORE && !channel_reg |=>
                                  local_value_reg == $past(avg[10:3]))
    else $error("local value not the integer part of the average");
  channel_flip_a: assert property (state_reg == S_COMPARE |=> channel_reg != $past(channel_reg))
    else $error("channel did not alternate");
  reset_values_a: assert property (state_reg == S_INIT |-> local_value_reg == 8'h80 &&
                                   remote_value_reg == 11'h400 && offset == 11'h000)
    else $error("value or offset not at reset default");
  low_flag_a: assert property (state_reg == S_COMPARE && !channel_reg &&
                               widen(local_value_reg) < widen(local_llim_reg) |=>
                               flags_reg.local_under_limit_flag)
    else $error("local low flag not set");
  alert_on_a: assert property ((|flags_reg) && !config_reg[7] |=> !ALERT_B)
    else $error("alert not asserted with active flag");
  mask_release_a: assert property (config_reg[7] |=> ALERT_B)
    else $error("alert asserted while masked");
  status_clear_a: assert property (status_read && flags_set == 4'h0 |=> flags_reg == 4'h0)
    else $error("status read did not clear flags");
  standby_halt_a: assert property (standby && state_reg inside {S_IDLE, S_START_LO} |=> !ADC_START)
    else $error("conversion started in standby");
endmodule // dtm_core

/* rtl/dtm_pkg.sv */
// ==========================================
// register map, resets, fields, timing
package dtm_pkg;
  // register pointer values
  localparam logic [7:0] REG_LOCAL_VALUE = 8'h00;
  localparam logic [7:0] REG_REMOTE_HIGH = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_LOCAL_HLIM = 8'h05;
  localparam logic [7:0] REG_LOCAL_LLIM = 8'h06;
  localparam logic [7:0] REG_REMOTE_HLIM_HIGH = 8'h07;
  localparam logic [7:0] REG_REMOTE_LLIM_HIGH = 8'h08;
  localparam logic [7:0] REG_REMOTE_LOW = 8'h10;
  localparam logic [7:0] REG_OFFSET_HIGH = 8'h11;
  localparam logic [7:0] REG_OFFSET_LOW = 8'h12;
  localparam logic [7:0] REG_REMOTE_HLIM_LOW = 8'h13;
  localparam logic [7:0] REG_REMOTE_LLIM_LOW = 8'h14;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  localparam logic [6:0] SMBUS_DEVICE_ADDR = 7'h2b;
  // reset values
  localparam logic [7:0] VALUE_RESET = 8'h80;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] LOCAL_HLIM_RESET = 8'h7f;
  localparam logic [7:0] LOCAL_LLIM_RESET = 8'h00;
  localparam logic [10:0] REMOTE_HLIM_RESET = 11'h3ff;
  localparam logic [10:0] REMOTE_LLIM_RESET = 11'h000;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h2;
  // field positions
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_FLAGS_LSB = 3;
  localparam int FRAC_BITS = 3;
  // averaging and timing
  localparam int AVG_SHIFT = 4;
  localparam logic [3:0] AVG_LAST = 4'hf;
  localparam logic [1:0] INIT_LAST = 2'h3;
  localparam logic [2:0] RATE_MAX = 3'h7;
  localparam int CLOCK_MHZ = 100;
  localparam int RATE_UNIT_US = 1000;
  localparam int RATE_UNIT_CYCLES = RATE_UNIT_US * CLOCK_MHZ;
  // carriers
  typedef logic signed [10:0] dtm_temp_t;
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } dtm_wr_s;
  typedef struct packed {
    logic local_high;
    logic local_under_limit_flag;
    logic remote_high;
    logic remote_under_limit_flag;
  } dtm_flags_s;
endpackage

/* rtl/dtm_sync2.sv */
`timescale 1ns/10ps
// ==========================================
// two-flop level synchroniser
module dtm_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // dtm_sync2

/* rtl/dtm_smbus_slave.sv */
`timescale 1ns/10ps
// ==========================================
// smbus byte engine on the link clock
module dtm_smbus_slave (
  // link clock and reset
  input wire logic link_clk,
  input wire logic rst_b,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // toward the core
  output dtm_pkg::dtm_wr_s wr_word,
  output logic wr_toggle,
  output logic rd_toggle,
  input wire logic rd_ack_toggle,
  input wire logic [7:0] rd_data
);
  typedef enum {L_IDLE, L_ADDR, L_ACK, L_WRITE, L_READ, L_MACK} dtm_link_e;
  dtm_link_e state_reg;
  logic scl_s, sda_s, ack_s, scl_d, sda_d, rw_reg, first_reg;
  logic [7:0] shift_reg, tx_reg, byte_next;
  logic [3:0] cnt_reg;

  dtm_sync2 #(.RESET_VAL(1'b1)) u_scl (.clk(link_clk), .rst_b(rst_b), .d(scl_in), .q(scl_s));
  dtm_sync2 #(.RESET_VAL(1'b1)) u_sda (.clk(link_clk), .rst_b(rst_b), .d(sda_in), .q(sda_s));
  dtm_sync2 u_ack (.clk(link_clk), .rst_b(rst_b), .d(rd_ack_toggle), .q(ack_s));

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      sda_out <= 1'b0;
    end
  end

  // a byte not yet answered by the core goes out as all ones
  assign byte_next = (ack_s == rd_toggle) ? rd_data : 8'hff;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= L_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      first_reg <= 1'b1;
      sda_oe <= 1'b0;
      wr_word <= '0;
      wr_toggle <= 1'b0;
      rd_toggle <= 1'b0;
    end else if (scl_s && scl_d && sda_d && !sda_s) begin
      state_reg <= L_ADDR;
      cnt_reg <= 4'h0;
      first_reg <= 1'b1;
      sda_oe <= 1'b0;
    end else if (scl_s && scl_d && !sda_d && sda_s) begin
      state_reg <= L_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_s && !scl_d) begin
      shift_reg <= {shift_reg[6:0], sda_s};
      cnt_reg <= cnt_reg + 4'h1;
      if (state_reg == L_MACK) begin
        if (sda_s) begin
          state_reg <= L_IDLE;
        end else begin
          rd_toggle <= ~rd_toggle;
        end
      end
    end else if (!scl_s && scl_d) begin
      case (state_reg)
        L_ADDR: begin
          if (cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == dtm_pkg::SMBUS_DEVICE_ADDR) begin
              sda_oe <= 1'b1;
              rw_reg <= shift_reg[0];
              state_reg <= L_ACK;
              if (shift_reg[0]) begin
                rd_toggle <= ~rd_toggle;
              end
            end else begin
              state_reg <= L_IDLE;
            end
          end
        end
        L_WRITE: begin
          if (cnt_reg == 4'h8) begin
            sda_oe <= 1'b1;
            wr_word <= '{first: first_reg, data: shift_reg};
            wr_toggle <= ~wr_toggle;
            first_reg <= 1'b0;
            state_reg <= L_ACK;
          end
        end
        L_ACK, L_MACK: begin
          cnt_reg <= 4'h0;
          if (rw_reg) begin
            sda_oe <= ~byte_next[7];
            tx_reg <= {byte_next[6:0], 1'b0};
            state_reg <= L_READ;
          end else begin
            sda_oe <= 1'b0;
            state_reg <= L_WRITE;
          end
        end
        L_READ: begin
          if (cnt_reg == 4'h8) begin
            sda_oe <= 1'b0;
            state_reg <= L_MACK;
          end else begin
            sda_oe <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule // dtm_smbus_slave

/* tb/dtm_adc_model.sv */
`timescale 1ns/10ps
// ==========================================
// converter model: fixed latency, dithered samples
module dtm_adc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // converter link
  input wire logic start,
  input wire logic chan,
  input wire logic bias,
  output logic done,
  output logic [10:0] data
);
  logic [2:0] cnt_reg;
  logic dith_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
      done <= 1'b0;
      dith_reg <= 1'b0;
      data <= 11'h000;
    end else begin
      done <= cnt_reg == 3'h1;
      cnt_reg <= start ? 3'h5 : cnt_reg - {2'h0, cnt_reg != 3'h0};
      // low-bias and idle data is junk, so a wrong capture shows
      data <= cnt_reg != 3'h1 ? ~data : !bias ? 11'h3ff :
        (chan ? 11'h193 : 11'h0c8) + (dith_reg ? 11'h008 : 11'h7f8);
      if (cnt_reg == 3'h1 && bias) dith_reg <= ~dith_reg;
    end
  end
endmodule // dtm_adc_model

/* tb/tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clock = 0;
  logic link_clk = 0;
  logic rst_b = 0;
  logic sclk = 1;
  logic sda_h = 1;
  logic standby_select_pin = 0;
  logic oe, al_b, ch, bias, go, done, sdo;
  logic [10:0] adc;
  logic [7:0] rd;
  int failures = 0;
  int check_count = 0;
  // pulled up; the device only ever pulls low
  wire sda = oe ? 1'b0 : sda_h;
  always #5 clock = ~clock;
  always #7.5 link_clk = ~link_clk;
  dtm_core #(.RATE_UNIT_CYCLES(20)) dut_u (.CLOCK(clock), .RST_B(rst_b), .LINK_CLK(link_clk), .SCLK(sclk),
    .SDATA_IN(sda), .SDATA_OUT(sdo), .SDATA_OE(oe), .STANDBY_SELECT_PIN(standby_select_pin), .ALERT_B(al_b),
    .ADC_CHANNEL(ch), .ADC_BIAS_HIGH(bias), .ADC_START(go), .ADC_DONE(done), .ADC_DATA(adc));
  dtm_adc_model adc_u (.clk(clock), .rst_b(rst_b), .start(go), .chan(ch), .bias(bias), .done(done), .data(adc));
  // ==========================================
  // serial bus host
  task automatic w(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic sbit(logic b);
    sda_h = b;
    w(20);
    sclk = 1;
    w(20);
    sclk = 0;
    w(2);
  endtask
  task automatic st();
    sda_h = 1;
    sclk = 1;
    w(20);
    sda_h = 0;
    w(20);
    sclk = 0;
    w(2);
  endtask
  task automatic sp();
    sda_h = 0;
    w(20);
    sclk = 1;
    w(20);
    sda_h = 1;
    w(40);
  endtask
  task automatic sb(logic [7:0] b);
    for (int i = 7; i >= 0; i--) sbit(b[i]);
    sda_h = 1;
    w(20);
    sclk = 1;
    `CHK("ack", 1'b0, sda)
    `CHK("sda_out", 1'b0, sdo)
    w(20);
    sclk = 0;
    w(2);
  endtask
  // one byte per read: every status read clears the flags again
  task automatic rb(logic last);
    sda_h = 1;
    for (int i = 7; i >= 0; i--) begin
      w(20);
      sclk = 1;
      w(10);
      rd[i] = sda;
      w(10);
      sclk = 0;
      w(2);
    end
    sbit(last);
  endtask
  task automatic ptr(logic [7:0] a);
    st();
    sb({dtm_pkg::SMBUS_DEVICE_ADDR, 1'b0});
    sb(a);
  endtask
  task automatic rw(logic [7:0] a, logic [7:0] d);
    ptr(a);
    sb(d);
    sp();
  endtask
  task automatic rr(logic [7:0] a, logic [7:0] e, logic [7:0] m);
    ptr(a);
    sp();
    st();
    sb({dtm_pkg::SMBUS_DEVICE_ADDR, 1'b1});
    rb(1);
    sp();
    `CHK("register", e, rd & m)
  endtask
  task automatic wf(logic sel, logic v);
    int k;
    for (k = 0; k < 20000 && (sel ? ch : al_b) !== v; k++) w(1);
    if (k == 20000) begin
      failures++;
      end_sim();
    end
  endtask
  // ==========================================
  // scenarios
  task automatic standby_power_up();
    wf(0, 0);
    `CHK("alert", 1'b0, al_b)
    rr(8'h00, 8'h80, 8'hff);
    rr(8'h01, 8'h80, 8'hff);
    rr(8'h11, 8'h00, 8'hff);
    rr(8'h12, 8'h00, 8'hff);
    rw(8'h06, 8'h80);
    rw(8'h08, 8'h80);
    rr(8'h02, 8'h28, 8'h78);
    wf(0, 1);
    `CHK("alert", 1'b1, al_b)
  endtask
  task automatic convert_offset();
    rw(8'h11, 8'h01);
    rw(8'h12, 8'h20);
    standby_select_pin = 1;
    wf(1, 1);
    wf(1, 0);
    rw(8'h00, 8'h55);
    rr(8'h00, 8'h19, 8'hff);
    rr(8'h01, 8'h33, 8'hff);
    rr(8'h10, 8'h80, 8'hff);
    rr(8'h20, 8'hff, 8'hff);
  endtask
  task automatic limit_and_mask();
    rw(8'h05, 8'h10);
    wf(0, 0);
    `CHK("alert", 1'b0, al_b)
    rw(8'h03, 8'h80);
    rr(8'h02, 8'h40, 8'h78);
    wf(1, 0);
    wf(1, 1);
    `CHK("alert", 1'b1, al_b)
    rr(8'h02, 8'h40, 8'h78);
    // fastest rate keeps the sequencer busy unless the standby bit stops it
    rw(8'h04, 8'h07);
    rr(8'h04, 8'h07, 8'hff);
    rw(8'h03, 8'hc0);
    rr(8'h02, 8'h00, 8'h80);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    w(20);
    rst_b = 1;
    standby_power_up();
    convert_offset();
    limit_and_mask();
    end_sim();
  end
endmodule // tb_top
